// ==== verilog/xcvr_pin_defs.vh ====
`ifndef XCVR_PIN_DEFS_VH
`define XCVR_PIN_DEFS_VH

// ----------------------------------------
// Mode state encodings
// ----------------------------------------
`define MODE_OFF 3'h0
`define MODE_IDLE 3'h1
`define MODE_HIBERNATE 3'h2
`define MODE_DOZE 3'h3
`define MODE_RECEIVE 3'h4
`define MODE_TRANSMIT 3'h5

// ----------------------------------------
// Host clock output selection codes
// ----------------------------------------
`define CLKSEL_16MHZ 3'h0
`define CLKSEL_8MHZ 3'h1
`define CLKSEL_4MHZ 3'h2
`define CLKSEL_2MHZ 3'h3
`define CLKSEL_1MHZ 3'h4
`define CLKSEL_62K5 3'h5
`define CLKSEL_32K786 3'h6
`define CLKSEL_16K393 3'h7
`define CLKSEL_RESET `CLKSEL_32K786

// ----------------------------------------
// Host clock output frequencies in Hz
// ----------------------------------------
`define FREQ_16MHZ_HZ 64'd16000000
`define FREQ_8MHZ_HZ 64'd8000000
`define FREQ_4MHZ_HZ 64'd4000000
`define FREQ_2MHZ_HZ 64'd2000000
`define FREQ_1MHZ_HZ 64'd1000000
`define FREQ_62K5_HZ 64'd62500
`define FREQ_32K786_HZ 64'd32787
`define FREQ_16K393_HZ 64'd16393

// ----------------------------------------
// Core clock rate and serial framing
// ----------------------------------------
`define CORE_CLK_HZ 64'd100000000
`define SPI_BYTE_BITS 4'h8
`define SPI_TX_RESET 8'h00

`endif

// ==== verilog/host_clock_divider.v ====
`timescale 1ns/1ns
`include "xcvr_pin_defs.vh"

module host_clock_divider #(
  parameter ACC_W = 32
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Control
  input wire [2:0] clk_sel,
  input wire run,
  // Output
  output reg host_clock_output
);

  // ----------------------------------------
  // Increment lookup
  // ----------------------------------------
  // Phase step = f * 2^ACC_W / core rate
  function [ACC_W-1:0] step_of;
    input [2:0] sel;
    reg [63:0] f;
    reg [63:0] q;
    begin
      case (sel)
        `CLKSEL_16MHZ: f = `FREQ_16MHZ_HZ;
        `CLKSEL_8MHZ: f = `FREQ_8MHZ_HZ;
        `CLKSEL_4MHZ: f = `FREQ_4MHZ_HZ;
        `CLKSEL_2MHZ: f = `FREQ_2MHZ_HZ;
        `CLKSEL_1MHZ: f = `FREQ_1MHZ_HZ;
        `CLKSEL_62K5: f = `FREQ_62K5_HZ;
        `CLKSEL_32K786: f = `FREQ_32K786_HZ;
        default: f = `FREQ_16K393_HZ;
      endcase
      // Every rate is below the core clock, so the quotient fits ACC_W bits
      q = (f << ACC_W) / `CORE_CLK_HZ;
      step_of = q[ACC_W-1:0];
    end
  endfunction

  reg [ACC_W-1:0] acc_q; // Phase accumulator

  // ----------------------------------------
  // Accumulator; MSB is the output clock
  // ----------------------------------------
  // Not an integer divide of the core clock, so fast rates carry
  // one core period of edge jitter; the truncated step runs the average frequency slightly low.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= {ACC_W{1'b0}};
      host_clock_output <= 1'b0;
    end else if (run) begin
      acc_q <= acc_q + step_of(clk_sel);
      host_clock_output <= acc_q[ACC_W-1];
    end else begin
      // Parked low while oscillator is off
      acc_q <= {ACC_W{1'b0}};
      host_clock_output <= 1'b0;
    end
  end

endmodule // host_clock_divider

// ==== verilog/xcvr_pin_control.v ====
// Function
// - reset low holds off mode, clears state
// - reset release enters idle, defaults restored
// - trigger rising edge starts receive or transmit
// - trigger low forces idle
// - wake low leaves hibernate or doze
// - host clock programmable, defaults 32.786 kHz
// - alternate enable makes pin two CRC-valid
// - alternate enable makes pin one out-of-idle
// - serial transfers only while chip enable low
// - host clocks serial port; dedicated data pins
// - general pins come up as inputs
// - MISO floats or drives low when deselected
`timescale 1ns/1ns
`include "xcvr_pin_defs.vh"

module xcvr_pin_control #(
  parameter SYNC_W = 5
) (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Mode control pins from host
  input wire radio_sequence_trigger,
  input wire wake_request_pin_n,
  // Configuration bits
  input wire rx_tx_select,
  input wire hibernate_req,
  input wire doze_req,
  input wire [2:0] clk_sel,
  input wire clk_sel_load,
  input wire gpio_alt_en,
  input wire miso_float_en,
  input wire gpio_one_dir,
  input wire gpio_one_out,
  input wire gpio_two_dir,
  input wire gpio_two_out,
  input wire crc_valid,
  // Serial port pins
  input wire spi_clk,
  input wire spi_cs_n,
  input wire mosi,
  output reg miso_out,
  output reg miso_oe,
  // Serial port user side
  input wire [7:0] spi_tx_byte,
  output reg [7:0] spi_rx_byte,
  output reg spi_rx_valid,
  // General I/O pins
  input wire general_io_pin_one_in,
  output reg general_io_pin_one_out,
  output reg general_io_pin_one_oe,
  input wire general_io_pin_two_in,
  output reg general_io_pin_two_out,
  output reg general_io_pin_two_oe,
  output reg gpio_one_value,
  output reg gpio_two_value,
  // Status and clock out
  output reg [2:0] mode_q,
  output wire host_clock_output
);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Bit order: trigger, wake_n, spi_clk, cs_n, mosi
  localparam B_TRIG = 4;
  localparam B_WAKE = 3;
  localparam B_SCK = 2;
  localparam B_CS = 1;
  localparam B_MOSI = 0;

  wire [SYNC_W-1:0] raw_pins; // Asynchronous pin levels
  reg [SYNC_W-1:0] s1_q; // First stage, read by s2 only
  reg [SYNC_W-1:0] s2_q; // Second stage
  reg [SYNC_W-1:0] s3_q; // Third stage
  reg [SYNC_W-1:0] filt_q; // Accepted level
  reg [SYNC_W-1:0] filt_d; // Next accepted level
  reg [1:0] gp_s1_q; // General pin first stage
  reg [1:0] gp_s2_q; // General pin second stage
  reg [1:0] gp_s3_q; // General pin third stage

  assign raw_pins = {radio_sequence_trigger, wake_request_pin_n, spi_clk, spi_cs_n, mosi};

  // Level moves only when second and third stages agree
  always @* begin
    filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
  end

  // Three-stage chains; cs_n and wake_n idle high at reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 5'h0a;
      s2_q <= 5'h0a;
      s3_q <= 5'h0a;
      filt_q <= 5'h0a;
      gp_s1_q <= 2'h0;
      gp_s2_q <= 2'h0;
      gp_s3_q <= 2'h0;
      gpio_one_value <= 1'b0;
      gpio_two_value <= 1'b0;
    end else begin
      s1_q <= raw_pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
      gp_s1_q <= {general_io_pin_two_in, general_io_pin_one_in};
      gp_s2_q <= gp_s1_q;
      gp_s3_q <= gp_s2_q;
      // Pin read-back once two stages agree
      if (gp_s2_q[0] == gp_s3_q[0]) begin
        gpio_one_value <= gp_s3_q[0];
      end
      if (gp_s2_q[1] == gp_s3_q[1]) begin
        gpio_two_value <= gp_s3_q[1];
      end
    end
  end

  // Edge events from the accepted levels
  wire trig_level = filt_q[B_TRIG];
  wire trig_rise = filt_d[B_TRIG] & ~filt_q[B_TRIG];
  wire wake_active = ~filt_q[B_WAKE];
  wire sck_rise = filt_d[B_SCK] & ~filt_q[B_SCK];
  wire sck_fall = ~filt_d[B_SCK] & filt_q[B_SCK];
  wire cs_active = ~filt_q[B_CS];
  wire cs_start = ~filt_d[B_CS] & filt_q[B_CS];

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  reg [2:0] mode_d; // Next mode

  always @* begin
    mode_d = mode_q;
    case (mode_q)
      `MODE_OFF: begin
        mode_d = `MODE_IDLE;
      end
      `MODE_IDLE: begin
        // Trigger edge wins over low-power requests
        if (trig_rise) begin
          mode_d = rx_tx_select ? `MODE_TRANSMIT : `MODE_RECEIVE;
        end else if (hibernate_req) begin
          mode_d = `MODE_HIBERNATE;
        end else if (doze_req) begin
          mode_d = `MODE_DOZE;
        end
      end
      `MODE_HIBERNATE, `MODE_DOZE: begin
        if (wake_active) begin
          mode_d = `MODE_IDLE;
        end
      end
      `MODE_RECEIVE, `MODE_TRANSMIT: begin
        // Host holds the trigger high for the sequence
        if (!trig_level) begin
          mode_d = `MODE_IDLE;
        end
      end
      default: begin
        mode_d = `MODE_IDLE;
      end
    endcase
  end

  // Off while reset is low; idle one edge after release
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `MODE_OFF;
    end else begin
      mode_q <= mode_d;
    end
  end

  // ----------------------------------------
  // Host clock output
  // ----------------------------------------
  reg [2:0] clk_sel_q; // Stored selection

  // Selection survives until reset; default restored on reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_q <= `CLKSEL_RESET;
    end else if (clk_sel_load) begin
      clk_sel_q <= clk_sel;
    end
  end

  // Oscillator is stopped in off and hibernate
  wire osc_run = (mode_q != `MODE_OFF) && (mode_q != `MODE_HIBERNATE);

  host_clock_divider u_clkdiv (
    .clk(clk),
    .rst_n(rst_n),
    .clk_sel(clk_sel_q),
    .run(osc_run),
    .host_clock_output(host_clock_output)
  );

  // ----------------------------------------
  // General I/O pins
  // ----------------------------------------
  // Outputs registered; both pins inputs out of reset
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      general_io_pin_one_out <= 1'b0;
      general_io_pin_one_oe <= 1'b0;
      general_io_pin_two_out <= 1'b0;
      general_io_pin_two_oe <= 1'b0;
    end else if (gpio_alt_en) begin
      // Status indicators take both pins
      general_io_pin_one_out <= (mode_d != `MODE_IDLE);
      general_io_pin_one_oe <= 1'b1;
      general_io_pin_two_out <= crc_valid;
      general_io_pin_two_oe <= 1'b1;
    end else begin
      general_io_pin_one_out <= gpio_one_out;
      general_io_pin_one_oe <= gpio_one_dir;
      general_io_pin_two_out <= gpio_two_out;
      general_io_pin_two_oe <= gpio_two_dir;
    end
  end

  // ----------------------------------------
  // Serial slave port
  // ----------------------------------------
  // Oscillator must run to catch host clock edges; the port is deaf in
  // hibernate, matching a stopped core clock, and in doze as well.
  wire spi_live = osc_run && (mode_q != `MODE_DOZE);

  reg [7:0] rx_shift_q; // Incoming bits
  reg [7:0] tx_shift_q; // Outgoing bits
  reg [3:0] bit_cnt_q; // Bits taken this byte

  // Sample on rising, shift out on falling, MSB first
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_shift_q <= 8'h00;
      tx_shift_q <= `SPI_TX_RESET;
      bit_cnt_q <= 4'h0;
      spi_rx_byte <= 8'h00;
      spi_rx_valid <= 1'b0;
    end else begin
      spi_rx_valid <= 1'b0;
      if (!cs_active || !spi_live) begin
        // Clock ignored while deselected
        bit_cnt_q <= 4'h0;
        if (cs_start) begin
          tx_shift_q <= spi_tx_byte;
        end
      end else begin
        if (sck_rise) begin
          rx_shift_q <= {rx_shift_q[6:0], filt_q[B_MOSI]};
          if (bit_cnt_q == `SPI_BYTE_BITS - 4'h1) begin
            bit_cnt_q <= 4'h0;
            spi_rx_byte <= {rx_shift_q[6:0], filt_q[B_MOSI]};
            spi_rx_valid <= 1'b1;
          end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end
        end
        if (sck_fall) begin
          // Reload after a whole byte, else shift
          if (bit_cnt_q == 4'h0) begin
            tx_shift_q <= spi_tx_byte;
          end else begin
            tx_shift_q <= {tx_shift_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  // MISO drive: data when selected, else float or low
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else if (cs_active && spi_live) begin
      miso_out <= tx_shift_q[7];
      miso_oe <= 1'b1;
    end else begin
      miso_out <= 1'b0;
      miso_oe <= ~miso_float_en;
    end
  end

endmodule // xcvr_pin_control

// ==== verification/xcvr_pin_checker.sv ====
`timescale 1ns/1ns
module xcvr_pin_checker (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Mode pins and requests
  input wire radio_sequence_trigger,
  input wire wake_request_pin_n,
  input wire rx_tx_select,
  input wire hibernate_req,
  input wire doze_req,
  input wire gpio_alt_en,
  input wire miso_float_en,
  input wire crc_valid,
  // Serial port
  input wire spi_cs_n,
  input wire miso_out,
  input wire miso_oe,
  input wire spi_rx_valid,
  // Pins and status
  input wire general_io_pin_one_out,
  input wire general_io_pin_one_oe,
  input wire general_io_pin_two_out,
  input wire general_io_pin_two_oe,
  input wire [2:0] mode_q
);
  // ----------------------------------------
  // One domain, reset disables everything
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_reset_idle; $rose(rst_n) |=> mode_q == 3'h1; endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("no idle after reset");
  // Synchroniser delay bounds the start window
  property p_start; mode_q == 3'h1 && $rose(radio_sequence_trigger) && !hibernate_req && !doze_req
    |-> ##[2:6] mode_q == {2'b10, rx_tx_select}; endproperty
  a_start: assert property (p_start) else $error("sequence did not start");
  property p_force_idle; mode_q[2] && $fell(radio_sequence_trigger) |-> ##[2:6] mode_q == 3'h1; endproperty
  a_force_idle: assert property (p_force_idle) else $error("trigger low kept busy");
  property p_wake; (mode_q == 3'h2 || mode_q == 3'h3) && $fell(wake_request_pin_n)
    |-> ##[2:6] mode_q == 3'h1; endproperty
  a_wake: assert property (p_wake) else $error("wake ignored");
  property p_alt_one; gpio_alt_en |=> general_io_pin_one_oe && general_io_pin_one_out == (mode_q != 3'h1); endproperty
  a_alt_one: assert property (p_alt_one) else $error("out of idle pin wrong");
  property p_alt_two; gpio_alt_en |=> general_io_pin_two_oe && general_io_pin_two_out == $past(crc_valid); endproperty
  a_alt_two: assert property (p_alt_two) else $error("crc valid pin wrong");
  // Deselected long enough for the synchroniser to settle
  property p_miso_idle; spi_cs_n [*6] ##0 $stable(miso_float_en) |-> miso_oe == !miso_float_en && !miso_out; endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso wrong when deselected");
  property p_no_rx; spi_cs_n [*8] |-> !spi_rx_valid; endproperty
  a_no_rx: assert property (p_no_rx) else $error("byte while deselected");
  property p_rx_pulse; spi_rx_valid |=> !spi_rx_valid; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx valid too long");
endmodule // xcvr_pin_checker

bind xcvr_pin_control xcvr_pin_checker chk (.*);

// ==== verification/host_model.sv ====
`timescale 1ns/1ns
module host_model (
  // Pins driven by the host
  output reg spi_clk,
  output reg spi_cs_n,
  output reg mosi,
  output reg radio_sequence_trigger,
  output reg wake_request_pin_n,
  // Pins driven by the device
  input wire miso_out,
  input wire miso_oe
);
  // Released miso is seen floating
  wire miso = miso_oe ? miso_out : 1'bz;
  // ----------------------------------------
  // Pins always driven, never left floating
  // ----------------------------------------
  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    mosi = 1'b0;
    radio_sequence_trigger = 1'b0;
    wake_request_pin_n = 1'b1;
  end
  // One framed byte, MSB first, clock idles low
  task xfer(input [7:0] tx, output [7:0] rx);
    integer i;
    begin
      spi_cs_n = 1'b0;
      #80;
      for (i = 7; i >= 0; i = i - 1) begin
        mosi = tx[i];
        #80 spi_clk = 1'b1;
        rx[i] = miso;
        #80 spi_clk = 1'b0;
      end
      #80 spi_cs_n = 1'b1;
      // Stale data line after the frame, not a held level
      mosi = ~tx[0];
      #320;
    end
  endtask
endmodule // host_model

// ==== verification/xcvr_pin_control_tb.sv ====
`timescale 1ns/1ns
module xcvr_pin_control_tb;
  // Bench state
  reg clk, rst_n, rx_tx_select, hibernate_req, doze_req, clk_sel_load, gpio_alt_en, miso_float_en;
  reg gpio_one_dir, gpio_one_out, gpio_two_dir, gpio_two_out, crc_valid, pin_one_in, pin_two_in;
  reg [2:0] clk_sel;
  reg [7:0] tx_byte, b, r, last;
  integer fails, n_tests, seed, i, t0;
  integer n_rx; // Received-byte pulses seen
  reg [31:0] rv; // Raw random word, sliced on purpose
  // Device outputs and host pins
  wire spi_clk, spi_cs_n, mosi, trig, wake_n, miso_out, miso_oe, spi_rx_valid, host_clock_output;
  wire one_out, one_oe, two_out, two_oe, one_val, two_val;
  wire [7:0] spi_rx_byte;
  wire [2:0] mode_q;
  // ----------------------------------------
  // Design and host
  // ----------------------------------------
  xcvr_pin_control dut (.clk(clk), .rst_n(rst_n), .radio_sequence_trigger(trig), .wake_request_pin_n(wake_n),
    .rx_tx_select(rx_tx_select), .hibernate_req(hibernate_req), .doze_req(doze_req), .clk_sel(clk_sel),
    .clk_sel_load(clk_sel_load), .gpio_alt_en(gpio_alt_en), .miso_float_en(miso_float_en),
    .gpio_one_dir(gpio_one_dir), .gpio_one_out(gpio_one_out), .gpio_two_dir(gpio_two_dir),
    .gpio_two_out(gpio_two_out), .crc_valid(crc_valid), .spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .mosi(mosi),
    .miso_out(miso_out), .miso_oe(miso_oe), .spi_tx_byte(tx_byte), .spi_rx_byte(spi_rx_byte),
    .spi_rx_valid(spi_rx_valid), .general_io_pin_one_in(pin_one_in), .general_io_pin_one_out(one_out),
    .general_io_pin_one_oe(one_oe), .general_io_pin_two_in(pin_two_in), .general_io_pin_two_out(two_out),
    .general_io_pin_two_oe(two_oe), .gpio_one_value(one_val), .gpio_two_value(two_val), .mode_q(mode_q),
    .host_clock_output(host_clock_output));
  host_model h (.spi_clk(spi_clk), .spi_cs_n(spi_cs_n), .mosi(mosi), .radio_sequence_trigger(trig),
    .wake_request_pin_n(wake_n), .miso_out(miso_out), .miso_oe(miso_oe));
  // 100 MHz core clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Count byte pulses; a missing or doubled pulse shows in the total
  always @(posedge clk) begin
    if (spi_rx_valid) begin
      n_rx <= n_rx + 1;
    end
  end
  // Clock cycles in four output periods, dividers of 16 MHz
  function integer exp_span(input [2:0] c);
    begin
      exp_span = 25 * ((c < 5) ? (1 << c) : (c == 5) ? 256 : (c == 6) ? 488 : 976);
    end
  endfunction
  // Advance, then drive just after the edge
  task step(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  // Exact value compare
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Span compare, one clock of jitter per edge allowed
  task chk_span(input [2:0] c);
    begin
      @(posedge host_clock_output);
      t0 = $time;
      repeat (4) @(posedge host_clock_output);
      n_tests = n_tests + 1;
      if (($time - t0) / 10 < exp_span(c) - 2 || ($time - t0) / 10 > exp_span(c) + 2) begin
        fails = fails + 1;
        $display("unexpected at %0t: clock code %0d span %0d", $time, c, ($time - t0) / 10);
      end
      // Back to the usual drive offset after the edge
      #1;
    end
  endtask
  // Single ending point
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
        $display("== PASSED ==");
      end else begin
        $display("== FAILED ==");
      end
      $finish;
    end
  endtask
  // Watchdog well past the clock measurements
  initial begin
    #960000;
    fails = fails + 1;
    report_and_stop;
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    fails = 0;
    n_tests = 0;
    n_rx = 0;
    seed = 32'hc94b;
    rst_n = 1'b0;
    {rx_tx_select, hibernate_req, doze_req, clk_sel_load, gpio_alt_en, crc_valid} = 6'h00;
    {gpio_one_dir, gpio_one_out, gpio_two_dir, gpio_two_out, pin_one_in, pin_two_in} = 6'h00;
    miso_float_en = 1'b1;
    clk_sel = 3'h0;
    tx_byte = 8'h00;
    step(20);
    chk({mode_q, miso_oe, one_oe, two_oe}, 8'h00);
    rst_n = 1'b1;
    step(3);
    chk(mode_q, 8'h01);
    chk_span(3'h6);
    // Plain pins follow their settings
    for (i = 0; i < 4; i = i + 1) begin
      rv = $random(seed);
      {gpio_one_dir, gpio_one_out, gpio_two_dir, gpio_two_out, pin_one_in, pin_two_in} = rv[5:0];
      step(5);
      chk({one_oe, one_out, two_oe, two_out, one_val, two_val},
          {gpio_one_dir, gpio_one_out, gpio_two_dir, gpio_two_out, pin_one_in, pin_two_in});
    end
    // Bytes both ways, corners first
    for (i = 0; i < 6; i = i + 1) begin
      rv = $random(seed);
      b = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : rv[7:0];
      tx_byte = rv[15:8];
      miso_float_en = i[0];
      h.xfer(b, r);
      chk(spi_rx_byte, b);
      chk(r, tx_byte);
      chk({miso_oe, miso_out}, {~miso_float_en, 1'b0});
    end
    chk(n_rx[7:0], 8'h06);
    last = b;
    // Sequences and low power with indicators on
    gpio_alt_en = 1'b1;
    for (i = 0; i < 2; i = i + 1) begin
      rv = $random(seed);
      crc_valid = rv[0];
      rx_tx_select = i[0];
      step(2);
      h.radio_sequence_trigger = 1'b1;
      step(8);
      chk(mode_q, {6'h02, rx_tx_select});
      chk({one_out, two_out}, {1'b1, crc_valid});
      h.radio_sequence_trigger = 1'b0;
      step(8);
      chk({mode_q, one_out}, 8'h02);
      {hibernate_req, doze_req} = i[0] ? 2'b01 : 2'b10;
      step(1);
      {hibernate_req, doze_req} = 2'b00;
      step(3);
      chk(mode_q, 8'h02 + i[7:0]);
      h.xfer(8'h5a, r);
      chk(spi_rx_byte, last);
      h.wake_request_pin_n = 1'b0;
      step(8);
      chk(mode_q, 8'h01);
      h.wake_request_pin_n = 1'b1;
    end
    // Port deaf in low power: no extra byte pulses
    chk(n_rx[7:0], 8'h06);
    // Every clock code
    for (i = 0; i < 8; i = i + 1) begin
      clk_sel = i[2:0];
      clk_sel_load = 1'b1;
      step(1);
      clk_sel_load = 1'b0;
      chk_span(i[2:0]);
      step(1);
    end
    // Mid-run reset with indicators driving and code 7 loaded
    rst_n = 1'b0;
    step(2);
    chk({mode_q, one_oe, two_oe, host_clock_output}, 8'h00);
    rst_n = 1'b1;
    step(2);
    chk(mode_q, 8'h01);
    chk_span(3'h6);
    report_and_stop;
  end
endmodule // xcvr_pin_control_tb
